// [src/adctsc_pkg.sv]
package adctsc_pkg;

  // APB byte addresses of the registers
  localparam logic [11:0] ADDR_TSEL0 = 12'h000;
  localparam logic [11:0] ADDR_TSEL1 = 12'h004;
  localparam logic [11:0] ADDR_CMPU0 = 12'h008;
  localparam logic [11:0] ADDR_CMPU1 = 12'h00C;
  localparam logic [11:0] ADDR_STAT = 12'h010;

  localparam logic [7:0] TSEL_RESET = 8'h10;
  localparam logic [7:0] CMP_RESET = 8'h00;
  // Writable bits; all others read zero
  localparam logic [7:0] TSEL_MASK = 8'hBB;
  localparam logic [7:0] CMPU0_MASK = 8'h11;
  localparam logic [7:0] CMPU1_MASK = 8'h77;

  localparam int SELA_LSB = 0;
  localparam int LDA_BIT = 3;
  localparam int SELB_LSB = 4;
  localparam int LDB_BIT = 7;
  localparam int FULL_LSB = 4;
  localparam int LOW_LSB = 0;

  typedef enum logic [1:0] {
    MODE_HW_TRIGGER,
    MODE_CHANNEL_SPEC,
    MODE_EXT_BUFFER
  } adctsc_mode_t;

  // Trigger routing for one converter unit
  typedef struct packed {
    logic [3:0] mainTrigger;
    logic [3:0] selTriggerA;
    logic [3:0] selTriggerB;
    logic loadTriggerA;
    logic loadTriggerB;
  } adctsc_route_t;

endpackage : adctsc_pkg

// [src/adctsc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module adctsc_ctrl
  import adctsc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter status
  input wire adctsc_mode_t mode0,
  input wire adctsc_mode_t mode1,
  input wire logic [1:0] convEnable,
  input wire logic [1:0] convBusy,
  // Trigger routing
  output adctsc_route_t route0,
  output adctsc_route_t route1,
  // Comparator enables
  output logic u0FullEnable,
  output logic u0LowEnable,
  output logic [2:0] u1FullEnable,
  output logic [2:0] u1LowEnable
);

  logic [7:0] tsel [2];
  logic [7:0] cmpU0;
  logic [7:0] cmpU1;
  logic [1:0] writeWhileRun;

  function automatic logic [3:0] decodeTrigger(input logic [1:0] field);
    decodeTrigger = 4'h1 << field;
  endfunction : decodeTrigger

  function automatic adctsc_route_t makeRoute(input logic [7:0] r, input adctsc_mode_t m);
    adctsc_route_t rt;
    rt.mainTrigger = decodeTrigger(r[SELA_LSB +: 2]);
    rt.selTriggerA = (m == MODE_EXT_BUFFER) ? decodeTrigger(r[SELA_LSB +: 2]) : 4'h0;
    rt.selTriggerB = (m == MODE_EXT_BUFFER) ? decodeTrigger(r[SELB_LSB +: 2]) : 4'h0;
    rt.loadTriggerA = r[LDA_BIT];
    rt.loadTriggerB = r[LDB_BIT];
    if (m != MODE_EXT_BUFFER) begin
      rt.loadTriggerA = 1'b0;
      rt.loadTriggerB = 1'b0;
    end
    makeRoute = rt;
  endfunction : makeRoute

  wire logic setupWrite = psel && !penable && pwrite;
  wire logic access = psel && penable;
  wire logic wr = access && pwrite && pready;
  // Whole-byte only registers need lane 0 strobe; bit access is a byte rewrite
  wire logic lane0 = pstrb[0];
  wire logic hitT0 = paddr == ADDR_TSEL0;
  wire logic hitT1 = paddr == ADDR_TSEL1;
  wire logic hitC0 = paddr == ADDR_CMPU0;
  wire logic hitC1 = paddr == ADDR_CMPU1;
  wire logic hitSt = paddr == ADDR_STAT;
  wire logic mapped = hitT0 || hitT1 || hitC0 || hitC1 || hitSt;

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      pready <= 1'b0;
    end else begin
      pready <= access && !pready;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access && !pready && !mapped;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (access && !pready && !pwrite) begin
      if (hitT0) begin
        prdata <= {24'h00_0000, tsel[0]};
      end else if (hitT1) begin
        prdata <= {24'h00_0000, tsel[1]};
      end else if (hitC0) begin
        prdata <= {24'h00_0000, cmpU0};
      end else if (hitC1) begin
        prdata <= {24'h00_0000, cmpU1};
      end else if (hitSt) begin
        prdata <= {30'h0000_0000, writeWhileRun};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Trigger select registers; reserved bits 6 and 2 stay zero
  always_ff @(posedge clock) begin
    if (srst) begin
      tsel[0] <= TSEL_RESET;
      tsel[1] <= TSEL_RESET;
    end else if (wr && lane0) begin
      if (hitT0) begin
        tsel[0] <= pwdata[7:0] & TSEL_MASK;
      end
      if (hitT1) begin
        tsel[1] <= pwdata[7:0] & TSEL_MASK;
      end
    end
  end

  // Sticky flag: changed value while converter was enabled; software clears by writing 1
  always_ff @(posedge clock) begin
    if (srst) begin
      writeWhileRun <= 2'b00;
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (wr && lane0 && ((u == 0) ? hitT0 : hitT1) && convEnable[u]
            && ((pwdata[7:0] & TSEL_MASK) != tsel[u])) begin
          writeWhileRun[u] <= 1'b1;
        end else if (wr && lane0 && hitSt && pwdata[u]) begin
          writeWhileRun[u] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cmpU0 <= CMP_RESET;
      cmpU1 <= CMP_RESET;
    end else if (wr && lane0) begin
      if (hitC0) begin
        cmpU0 <= pwdata[7:0] & CMPU0_MASK;
      end
      if (hitC1) begin
        cmpU1 <= pwdata[7:0] & CMPU1_MASK;
      end
    end
  end

  // Routing is held while a conversion runs so it sees one stable selection
  always_ff @(posedge clock) begin
    if (srst) begin
      route0 <= makeRoute(TSEL_RESET, MODE_HW_TRIGGER);
      route1 <= makeRoute(TSEL_RESET, MODE_HW_TRIGGER);
    end else begin
      if (!convBusy[0]) begin
        route0 <= makeRoute(tsel[0], mode0);
      end
      if (!convBusy[1]) begin
        route1 <= makeRoute(tsel[1], mode1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      u0FullEnable <= 1'b0;
      u0LowEnable <= 1'b0;
      u1FullEnable <= 3'b000;
      u1LowEnable <= 3'b000;
    end else begin
      u0FullEnable <= cmpU0[FULL_LSB];
      u0LowEnable <= cmpU0[LOW_LSB];
      u1FullEnable <= cmpU1[FULL_LSB +: 3];
      u1LowEnable <= cmpU1[LOW_LSB +: 3];
    end
  end

  // APB handshake steps
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  sequence s_answer;
    !pready ##1 pready;
  endsequence

  a_tsel_reset: assert property (@(posedge clock)
    $fell(srst) |-> tsel[0] == TSEL_RESET && tsel[1] == TSEL_RESET)
    else $error("trigger select not at reset value");

  a_tsel_write: assert property (@(posedge clock) disable iff (srst)
    wr && lane0 && hitT0 |=> tsel[0] == ($past(pwdata[7:0]) & TSEL_MASK))
    else $error("trigger select write lost");

  a_tsel1_write: assert property (@(posedge clock) disable iff (srst)
    wr && lane0 && hitT1 |=> tsel[1] == ($past(pwdata[7:0]) & TSEL_MASK))
    else $error("unit one trigger select write lost");

  a_tsel_reserved: assert property (@(posedge clock) disable iff (srst)
    (tsel[0] & ~TSEL_MASK) == 8'h00 && (tsel[1] & ~TSEL_MASK) == 8'h00)
    else $error("trigger select reserved bit set");

  a_strobe_ignore: assert property (@(posedge clock) disable iff (srst)
    wr && !lane0
    |=> $stable(tsel[0]) && $stable(tsel[1]) && $stable(cmpU0) && $stable(cmpU1))
    else $error("write without lane zero strobe changed a register");

  a_route_decode: assert property (@(posedge clock) disable iff (srst)
    !convBusy[0] |=> route0.mainTrigger == (4'h1 << $past(tsel[0][1:0])))
    else $error("main trigger decode wrong");

  a_sela_decode: assert property (@(posedge clock) disable iff (srst)
    !convBusy[0] && mode0 == MODE_EXT_BUFFER
    |=> route0.selTriggerA == (4'h1 << $past(tsel[0][1:0])))
    else $error("selection trigger one decode wrong");

  a_selb_decode: assert property (@(posedge clock) disable iff (srst)
    !convBusy[1] && mode1 == MODE_EXT_BUFFER
    |=> route1.selTriggerB == (4'h1 << $past(tsel[1][5:4])))
    else $error("selection trigger two decode wrong");

  a_sel_idle: assert property (@(posedge clock) disable iff (srst)
    !convBusy[1] && mode1 != MODE_EXT_BUFFER
    |=> route1.selTriggerA == 4'h0 && route1.selTriggerB == 4'h0 && !route1.loadTriggerA)
    else $error("selection routing active outside extension mode");

  a_load_select: assert property (@(posedge clock) disable iff (srst)
    !convBusy[0] && mode0 == MODE_EXT_BUFFER
    |=> route0.loadTriggerA == $past(tsel[0][3]) && route0.loadTriggerB == $past(tsel[0][7]))
    else $error("load trigger choice wrong");

  a_flag_set: assert property (@(posedge clock) disable iff (srst)
    wr && lane0 && hitT0 && convEnable[0] && ((pwdata[7:0] & TSEL_MASK) != tsel[0])
    |=> writeWhileRun[0])
    else $error("change while enabled not flagged");

  a_flag_clear: assert property (@(posedge clock) disable iff (srst)
    wr && lane0 && hitSt && pwdata[0] |=> !writeWhileRun[0])
    else $error("status flag not cleared");

  a_cmp_reset: assert property (@(posedge clock)
    $fell(srst) |-> cmpU0 == CMP_RESET && cmpU1 == CMP_RESET)
    else $error("comparator control not cleared");

  a_cmp_reserved: assert property (@(posedge clock) disable iff (srst)
    (cmpU0 & ~CMPU0_MASK) == 8'h00 && (cmpU1 & ~CMPU1_MASK) == 8'h00)
    else $error("comparator reserved bit set");

  a_cmp0_write: assert property (@(posedge clock) disable iff (srst)
    wr && lane0 && hitC0 |=> cmpU0 == ($past(pwdata[7:0]) & CMPU0_MASK))
    else $error("unit zero comparator write lost");

  a_cmp1_write: assert property (@(posedge clock) disable iff (srst)
    wr && lane0 && hitC1 |=> cmpU1 == ($past(pwdata[7:0]) & CMPU1_MASK))
    else $error("unit one comparator write lost");

  a_cmp_enable: assert property (@(posedge clock) disable iff (srst)
    $changed(cmpU1) |=> u1FullEnable == cmpU1[6:4] && u1LowEnable == cmpU1[2:0])
    else $error("unit one comparator enable mismatch");

  a_u0_low: assert property (@(posedge clock) disable iff (srst)
    $changed(cmpU0) |=> u0LowEnable == cmpU0[LOW_LSB] && u0FullEnable == cmpU0[FULL_LSB])
    else $error("unit zero comparator enable mismatch");

  a_cmp_u0_enable: assert property (@(posedge clock) disable iff (srst)
    wr && lane0 && hitC0 |-> ##2 u0FullEnable == $past(pwdata[4], 2))
    else $error("unit zero full range enable mismatch");

  a_route_hold: assert property (@(posedge clock) disable iff (srst)
    convBusy[0] && $past(convBusy[0]) |-> $stable(route0))
    else $error("routing changed during conversion");

  a_apb_ready: assert property (@(posedge clock) disable iff (srst)
    s_setup ##1 s_access |-> s_answer)
    else $error("apb answer timing wrong");

  a_apb_setup: assert property (@(posedge clock) disable iff (srst)
    setupWrite |=> !pready)
    else $error("ready during setup");

  a_ready_pulse: assert property (@(posedge clock) disable iff (srst)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_err_pulse: assert property (@(posedge clock) disable iff (srst)
    pslverr |-> pready)
    else $error("error response without ready");

  a_unmapped_read: assert property (@(posedge clock) disable iff (srst)
    access && !pready && !pwrite && !mapped |=> prdata == 32'h0000_0000 && pslverr)
    else $error("unmapped read not refused");

endmodule : adctsc_ctrl
`default_nettype wire

// [verif/adctsc_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
module adctsc_ctrl_test
  import adctsc_pkg::*;
;
  logic clock, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  adctsc_mode_t mode0, mode1;
  logic [1:0] convEnable, convBusy;
  adctsc_route_t route0, route1;
  logic u0FullEnable, u0LowEnable, err;
  logic [2:0] u1FullEnable, u1LowEnable;
  logic [7:0] v;
  int nErrors = 0;
  int samplesChecked = 0;

  adctsc_ctrl adctsc_ctrl_i (.clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .mode0, .mode1, .convEnable, .convBusy,
    .route0, .route1, .u0FullEnable, .u0LowEnable, .u1FullEnable, .u1LowEnable);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic tally_and_finish;
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chkr(input string nm, input adctsc_route_t e, input adctsc_route_t g);
    samplesChecked++;
    if (g !== e) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chkr

  // Called just after a rising edge; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    err = pslverr;
    if (n >= 50) begin
      nErrors++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps release and next setup in separate time steps
    @(posedge clock);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    chk("rdata", e, rdat);
    chk("pslverr", 32'h0000_0000, {31'h0000_0000, err});
  endtask : rdc

  initial begin
    srst = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    mode0 = MODE_EXT_BUFFER;
    mode1 = MODE_HW_TRIGGER;
    convEnable = 2'b00;
    convBusy = 2'b00;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    chkr("route1", '{4'h1, 4'h0, 4'h0, 1'b0, 1'b0}, route1);
    rdc(ADDR_TSEL0, 32'h0000_0010);
    rdc(ADDR_TSEL1, 32'h0000_0010);
    rdc(ADDR_CMPU0, 32'h0000_0000);
    rdc(ADDR_CMPU1, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      v = 8'(k * 17) | (k[0] ? 8'h88 : 8'h00);
      wr(ADDR_TSEL0, v);
      rdc(ADDR_TSEL0, {24'h00_0000, v});
      chkr("route0", '{4'h1 << k, 4'h1 << k, 4'h1 << k, k[0], k[0]}, route0);
      chkr("route0", '{4'h1 << k, 4'h1 << k, 4'h1 << k, k[0], k[0]}, route0);
    end
    wr(ADDR_TSEL1, 8'h12);
    @(posedge clock);
    chkr("route1", '{4'h4, 4'h0, 4'h0, 1'b0, 1'b0}, route1);
    mode1 <= MODE_CHANNEL_SPEC;
    wr(ADDR_TSEL1, 8'h13);
    @(posedge clock);
    chkr("route1", '{4'h8, 4'h0, 4'h0, 1'b0, 1'b0}, route1);
    mode1 <= MODE_EXT_BUFFER;
    wr(ADDR_TSEL1, 8'hA3);
    @(posedge clock);
    chkr("route1", '{4'h8, 4'h8, 4'h4, 1'b0, 1'b1}, route1);
    convBusy <= 2'b01;
    wr(ADDR_TSEL0, 8'h10);
    chkr("route0", '{4'h8, 4'h8, 4'h8, 1'b1, 1'b1}, route0);
    convBusy <= 2'b00;
    repeat (3) @(posedge clock);
    chkr("route0", '{4'h1, 4'h1, 4'h2, 1'b0, 1'b0}, route0);
    // Changing the selection while enabled is only flagged, never blocked
    convEnable <= 2'b01;
    wr(ADDR_TSEL0, 8'h11);
    rdc(ADDR_STAT, 32'h0000_0001);
    convEnable <= 2'b00;
    wr(ADDR_STAT, 8'h01);
    rdc(ADDR_STAT, 32'h0000_0000);
    wr(ADDR_CMPU0, 8'hFF);
    rdc(ADDR_CMPU0, 32'h0000_0011);
    chk("u0en", 32'h0000_0003, {30'h0, u0FullEnable, u0LowEnable});
    wr(ADDR_CMPU1, 8'h25);
    rdc(ADDR_CMPU1, 32'h0000_0025);
    chk("u1en", 32'h0000_0015, {26'h0, u1FullEnable, u1LowEnable});
    wr(ADDR_CMPU1, 8'hFF);
    rdc(ADDR_CMPU1, 32'h0000_0077);
    pstrb <= 4'h2;
    wr(ADDR_CMPU1, 8'h00);
    pstrb <= 4'hF;
    rdc(ADDR_CMPU1, 32'h0000_0077);
    xfer(1'b0, 12'h020, 8'h00);
    chk("unmapped", 32'h0000_0001, {rdat[30:0], err});
    tally_and_finish();
  end

  initial begin
    repeat (3000) @(posedge clock);
    nErrors++;
    tally_and_finish();
  end
endmodule : adctsc_ctrl_test
`default_nettype wire
